/* File: design/bsc_pkg.sv */
package bsc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_KHZ      = 40000;
    localparam int SPI_SLOW_KHZ = 4500;
    localparam int SPI_MID_KHZ  = 9000;
    localparam int SPI_FAST_KHZ = 18000;
    // Half periods round up so no rate is ever exceeded
    localparam logic [3:0] SPI_HALF_SLOW = 4'((CLK_KHZ + 2*SPI_SLOW_KHZ - 1) / (2*SPI_SLOW_KHZ));
    localparam logic [3:0] SPI_HALF_MID  = 4'((CLK_KHZ + 2*SPI_MID_KHZ - 1) / (2*SPI_MID_KHZ));
    localparam logic [3:0] SPI_HALF_FAST = 4'((CLK_KHZ + 2*SPI_FAST_KHZ - 1) / (2*SPI_FAST_KHZ));

    // ************************************************************
    // Flash boot load
    // ************************************************************
    localparam logic [7:0]  FLASH_READ_CMD = 8'h03;
    localparam int          FLASH_ADDR_W   = 24;   // 16 MB byte space
    localparam logic [15:0] BOOT_END_MARK  = 16'hffff;
    localparam int          REC_W          = 16;
    localparam int          POS_W          = 20;

    // ************************************************************
    // Two-wire slave and registers
    // ************************************************************
    localparam logic [7:0]  TW_ID_STRAP_LO   = 8'h90;
    localparam logic [7:0]  TW_ID_STRAP_HI   = 8'hba;
    localparam logic [15:0] REG_CLK_CTL      = 16'h0014;
    localparam logic [15:0] REG_BOOT_STAT    = 16'h0016;
    localparam int          CLK_CTL_BIAS_BIT = 14;
    localparam logic [15:0] CLK_CTL_RST      = 16'h4000;

    // Synchroniser lanes
    localparam int IN_MISO  = 0;
    localparam int IN_SCL   = 1;
    localparam int IN_SDA   = 2;
    localparam int IN_STRAP = 3;
    localparam int IN_FS    = 4;

    typedef enum logic [1:0] {B_CMD, B_DATA, B_DONE} bsc_boot_type;
    typedef enum logic [2:0] {T_IDLE, T_ADDR, T_WR, T_ACK, T_RD, T_RACK} bsc_tw_type;

    typedef struct packed {
        logic sclk;
        logic flash_data_out;
        logic cs_n;
        logic oe;
    } bsc_spi_type;

    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [15:0] data;
    } bsc_cfg_type;

    typedef struct packed {
        logic [4:0]       sy1;
        logic [4:0]       sy2;
        logic [4:0]       prev;
        bsc_boot_type     boot;
        logic [3:0]       div;
        logic [5:0]       bitc;
        logic [31:0]      tx;
        logic [31:0]      rx;
        logic [REC_W-1:0] rec;
        bsc_spi_type      spi;
        bsc_cfg_type      cfg;
        logic [15:0]      clk_ctl;
        bsc_tw_type       tw;
        logic [3:0]       tw_bit;
        logic [7:0]       tw_sh;
        logic             tw_rw;
        logic [1:0]       tw_byte;
        logic [15:0]      tw_addr;
        logic [7:0]       tw_hi;
        logic             sda_oe;
        logic [POS_W-1:0] fpos;
        logic             falign;
    } bsc_state_type;

endpackage

/* File: design/bsc_top.sv */
// How it works
// - Reset returns every interface to idle
// - Reset release starts the flash boot
// - Boot loads setup records from flash
// - Flash address is 24 bits, 16 MB
// - Flash pins undriven while reset held
// - Drive clock, data, select; sample returned data
// - Strap picks slave id 0x90 or 0xba
// - Host reaches registers; data line open-drain
// - Bias enable bit 14 at 0x0014, resets 1
// - Frame sync edge realigns timing; always sampled
// - Flash clock at most 4.5, 9 or 18 MHz
`timescale 1ns/10ps
`default_nettype none
module bsc_top import bsc_pkg::*; #(
    parameter logic [FLASH_ADDR_W-1:0] BOOT_BASE    = 24'h000000,
    parameter logic [REC_W-1:0]        BOOT_MAX_REC = 16'h0100,
    parameter logic [POS_W-1:0]        FRAME_LEN    = 20'h00400
) (
    input  wire logic             clk_i,                // 40 MHz
    input  wire logic             rst_i,                // Sync, active high
    input  wire logic [1:0]       spi_rate_i,           // 0 slow, 1 mid, else fast
    input  wire logic             flash_data_in_i,      // Flash return data pin
    output bsc_spi_type           spi_o,                // Flash pins and enable
    input  wire logic             host_serial_clk_i,    // Two-wire clock pin
    input  wire logic             host_serial_dat_i,    // Two-wire data pin
    output logic                  host_serial_dat_o,    // Always low, open drain
    output logic                  host_serial_dat_oe_o, // Pull data line low
    input  wire logic             bus_id_select_i,      // Id strap pin
    input  wire logic             frame_sync_i,         // Frame sync pin
    output bsc_cfg_type           cfg_o,                // Register write strobe
    output logic                  bias_en_o,            // Oscillator bias resistor
    output logic                  boot_done_o,          // Boot load finished
    output logic [POS_W-1:0]      frame_pos_o,          // Frame timing position
    output logic                  frame_align_o         // Realign pulse
);

    bsc_state_type q;
    bsc_state_type d;
    logic [3:0]    half;
    logic          tick;
    logic [31:0]   rxn;
    logic          scl;
    logic          sda;
    logic          rise;
    logic          fall;
    logic [7:0]    tw_id;
    logic [15:0]   rdv;
    logic [7:0]    nxt;

    // ************************************************************
    // Next state
    // ************************************************************
    // Flash clock half period from the rate select
    always_comb begin
        if (spi_rate_i == 2'h0) begin
            half = SPI_HALF_SLOW;
        end else if (spi_rate_i == 2'h1) begin
            half = SPI_HALF_MID;
        end else begin
            half = SPI_HALF_FAST;
        end
    end

    // One process for every part of the block
    always_comb begin
        d      = q;
        rxn    = '0;
        nxt    = '0;
        d.cfg.wr = 1'b0;
        d.sy1  = {frame_sync_i, bus_id_select_i, host_serial_dat_i, host_serial_clk_i,
                  flash_data_in_i};
        d.sy2  = q.sy1;
        d.prev = q.sy2;
        tick   = (q.div == 4'(half - 4'h1));
        scl    = q.sy2[IN_SCL];
        sda    = q.sy2[IN_SDA];
        rise   = scl && !q.prev[IN_SCL];
        fall   = !scl && q.prev[IN_SCL];
        tw_id  = q.sy2[IN_STRAP] ? TW_ID_STRAP_HI : TW_ID_STRAP_LO;
        if (q.tw_addr == REG_CLK_CTL) begin
            rdv = q.clk_ctl;
        end else if (q.tw_addr == REG_BOOT_STAT) begin
            rdv = {15'h0000, q.boot == B_DONE};
        end else begin
            rdv = 16'h0000;
        end

        // boot runs straight out of reset
        case (q.boot)
            B_CMD, B_DATA: begin
                d.spi.cs_n = 1'b0;
                d.spi.oe   = 1'b1;
                if (tick) begin
                    d.div      = 4'h0;
                    d.spi.sclk = !q.spi.sclk;
                    // Sample on the falling tick: the synchroniser lag keeps us after rise
                    if (q.spi.sclk) begin
                        rxn    = {q.rx[30:0], q.sy2[IN_MISO]};
                        d.rx   = rxn;
                        d.tx   = {q.tx[30:0], 1'b0};
                        d.bitc = 6'(q.bitc + 6'h01);
                        if (q.bitc == 6'd31) begin
                            d.bitc = 6'h00;
                            if (q.boot == B_CMD) begin
                                d.boot = B_DATA;
                            end else if (rxn[31:16] == BOOT_END_MARK) begin
                                d.boot = B_DONE;
                            end else begin
                                d.cfg = '{wr: 1'b1, addr: rxn[31:16], data: rxn[15:0]};
                                d.rec = REC_W'(q.rec + 1'b1);
                                if (rxn[31:16] == REG_CLK_CTL) begin
                                    d.clk_ctl = rxn[15:0];
                                end
                                if (q.rec == REC_W'(BOOT_MAX_REC - 1'b1)) begin
                                    d.boot = B_DONE;
                                end
                            end
                        end
                    end
                end else begin
                    d.div = 4'(q.div + 4'h1);
                end
            end
            default: begin
                d.spi.cs_n = 1'b1;
                d.spi.sclk = 1'b0;
            end
        endcase
        d.spi.flash_data_out = d.tx[31];

        if (scl && q.prev[IN_SCL] && !q.prev[IN_SDA] && sda) begin
            d.tw     = T_IDLE;
            d.sda_oe = 1'b0;
        end else if (scl && q.prev[IN_SCL] && q.prev[IN_SDA] && !sda) begin
            d.tw     = T_ADDR;
            d.tw_bit = 4'h0;
            d.sda_oe = 1'b0;
        end else begin
            case (q.tw)
                T_ADDR, T_WR: begin
                    if (rise && q.tw_bit != 4'h8) begin
                        d.tw_sh  = {q.tw_sh[6:0], sda};
                        d.tw_bit = 4'(q.tw_bit + 4'h1);
                    end else if (fall && q.tw_bit == 4'h8) begin
                        d.tw     = T_ACK;
                        d.sda_oe = 1'b1;
                        if (q.tw == T_ADDR) begin
                            // Busy during boot: the host sees no acknowledge
                            if (q.tw_sh[7:1] == tw_id[7:1] && q.boot == B_DONE) begin
                                d.tw_rw   = q.tw_sh[0];
                                d.tw_byte = q.tw_sh[0] ? 2'h2 : 2'h0;
                            end else begin
                                d.tw     = T_IDLE;
                                d.sda_oe = 1'b0;
                            end
                        end else if (q.tw_byte == 2'h0) begin
                            d.tw_addr[15:8] = q.tw_sh;
                            d.tw_byte       = 2'h1;
                        end else if (q.tw_byte == 2'h1) begin
                            d.tw_addr[7:0] = q.tw_sh;
                            d.tw_byte      = 2'h2;
                        end else if (q.tw_byte == 2'h2) begin
                            d.tw_hi   = q.tw_sh;
                            d.tw_byte = 2'h3;
                        end else begin
                            d.cfg     = '{wr: 1'b1, addr: q.tw_addr, data: {q.tw_hi, q.tw_sh}};
                            d.tw_addr = 16'(q.tw_addr + 16'h0002);
                            d.tw_byte = 2'h2;
                            if (q.tw_addr == REG_CLK_CTL) begin
                                d.clk_ctl = {q.tw_hi, q.tw_sh};
                            end
                        end
                    end
                end
                T_ACK: begin
                    if (fall) begin
                        d.tw_bit = 4'h0;
                        d.sda_oe = 1'b0;
                        d.tw     = T_WR;
                        if (q.tw_rw) begin
                            nxt     = (q.tw_byte == 2'h2) ? rdv[15:8] : rdv[7:0];
                            d.tw_sh = nxt;
                            d.tw    = T_RD;
                            d.sda_oe = !nxt[7];
                            d.tw_byte = (q.tw_byte == 2'h2) ? 2'h3 : 2'h2;
                            if (q.tw_byte != 2'h2) begin
                                d.tw_addr = 16'(q.tw_addr + 16'h0002);
                            end
                        end
                    end
                end
                T_RD: begin
                    if (fall) begin
                        d.tw_bit = 4'(q.tw_bit + 4'h1);
                        d.tw_sh  = {q.tw_sh[6:0], 1'b0};
                        d.sda_oe = !q.tw_sh[6];
                        if (q.tw_bit == 4'h7) begin
                            d.sda_oe = 1'b0;
                            d.tw     = T_RACK;
                        end
                    end
                end
                T_RACK: begin
                    // Host acknowledge asks for the next byte
                    if (rise) begin
                        d.tw = sda ? T_IDLE : T_ACK;
                    end
                end
                default: begin
                    d.sda_oe = 1'b0;
                end
            endcase
        end

        if (q.sy2[IN_FS] && !q.prev[IN_FS]) begin
            d.fpos   = '0;
            d.falign = 1'b1;
        end else begin
            d.fpos   = (q.fpos == POS_W'(FRAME_LEN - 1'b1)) ? '0 : POS_W'(q.fpos + 1'b1);
            d.falign = 1'b0;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // reset idles all interfaces; flash pins released
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q          <= '0;
            q.spi.cs_n <= 1'b1;
            q.clk_ctl  <= CLK_CTL_RST;
            q.tx       <= {FLASH_READ_CMD, BOOT_BASE};
        end else begin
            q <= d;
        end
    end

    assign spi_o                = q.spi;
    assign cfg_o                = q.cfg;
    assign host_serial_dat_o    = 1'b0;
    assign host_serial_dat_oe_o = q.sda_oe;
    assign bias_en_o            = q.clk_ctl[CLK_CTL_BIAS_BIT];
    assign boot_done_o          = (q.boot == B_DONE);
    assign frame_pos_o          = q.fpos;
    assign frame_align_o        = q.falign;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i);
    endclocking

    logic [3:0] run_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || q.spi.sclk != d.spi.sclk) begin
            run_q <= 4'h0;
        end else begin
            run_q <= 4'(run_q + 4'h1);
        end
    end

    sequence fs_edge_s;
        q.sy2[IN_FS] && !q.prev[IN_FS];
    endsequence
    sequence realign_s;
        frame_align_o && frame_pos_o == '0;
    endsequence

    rst_idle_a: assert property (rst_i |=> q.tw == T_IDLE && !host_serial_dat_oe_o)
        else $error("interfaces not idle after reset");
    boot_start_a: assert property ($fell(rst_i) |=> !spi_o.cs_n)
        else $error("boot did not start");
    boot_write_a: assert property (disable iff (rst_i) cfg_o.wr && !boot_done_o |->
        cfg_o.addr != BOOT_END_MARK) else $error("end mark applied as record");
    cmd_addr_a: assert property (disable iff (rst_i) $fell(spi_o.cs_n) |->
        q.tx == {FLASH_READ_CMD, BOOT_BASE}) else $error("bad command or address");
    pins_hiz_a: assert property (rst_i |=> !spi_o.oe)
        else $error("flash pins driven in reset");
    clk_in_cs_a: assert property (disable iff (rst_i) $changed(spi_o.sclk) |->
        !$past(spi_o.cs_n)) else $error("flash clock outside select");
    id_match_a: assert property (disable iff (rst_i) q.tw == T_ADDR && d.tw == T_ACK |->
        q.tw_sh[7:1] == tw_id[7:1]) else $error("acked wrong id");
    sda_drive_a: assert property (disable iff (rst_i) host_serial_dat_oe_o |->
        q.tw == T_ACK || q.tw == T_RD) else $error("data line driven out of turn");
    bias_rst_a: assert property (rst_i |=> bias_en_o)
        else $error("bias bit not set by reset");
    fs_align_a: assert property (disable iff (rst_i) fs_edge_s |=> realign_s)
        else $error("frame sync edge ignored");
    rate_half_a: assert property (disable iff (rst_i) $changed(spi_o.sclk) &&
        $past(spi_o.sclk) |-> $past(run_q) + 4'h1 >= SPI_HALF_FAST) else $error("flash clock fast");
    msb_first_a: assert property (disable iff (rst_i) $fell(spi_o.sclk) && q.boot == B_CMD
        |-> spi_o.flash_data_out == q.tx[31]) else $error("data not MSB first");

endmodule
`default_nettype wire

/* File: test/bsc_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bsc_flash_model import bsc_pkg::*; (
    input  wire bsc_spi_type spi_i,  // Device flash pins
    input  wire logic        slow_i, // Late data change after clock fall
    output logic             data_o, // Return data pin
    output logic [31:0]      hdr_o   // Command and address word seen
);
    logic [7:0] mem [0:63]; // Small image, address wraps at 64 bytes
    int         nbits;
    int         k;
    int         dly;
    logic       sel;
    logic       sck;

    assign sel = (spi_i.oe === 1'b1) && (spi_i.cs_n === 1'b0);
    assign sck = (spi_i.oe === 1'b1) && (spi_i.sclk === 1'b1);

    initial begin
        nbits = 0;
        hdr_o = 32'h0;
        data_o = 1'b1;
    end

    // Deselected line goes to the pull-up, never holds the last bit
    always @(sel) begin
        if (!sel) begin
            nbits = 0;
            data_o <= 1'b1;
        end
    end

    always @(posedge sck) begin
        if (sel) begin
            if (nbits < 32) begin
                hdr_o = {hdr_o[30:0], spi_i.flash_data_out};
            end
            nbits = nbits + 1;
        end
    end

    // data changes on falling clock, MSB first
    always @(negedge sck) begin
        if (sel && nbits >= 32) begin
            k = nbits - 32;
            dly = slow_i ? 12 : 2;
            data_o <= #(dly) mem[6'(int'(hdr_o[5:0]) + k / 8)][7 - k % 8];
        end
    end
endmodule
`default_nettype wire

/* File: test/bsc_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module bsc_top_bench import bsc_pkg::*;;
    localparam logic [23:0] BASE = 24'hc0ffe0;
    localparam logic [19:0] FLEN = 20'h00010;
    logic        clk_i, rst_i, scl, sda, sda_w, strap, fsync, slow, fdata;
    logic        dat_o, dat_oe, bias, done, align, sclk_prev;
    logic [1:0]  rate;
    logic [19:0] pos;
    logic [95:0] img;
    bsc_spi_type spi;
    bsc_cfg_type cfg;
    logic [31:0] wq [$];
    int          err_total, comparisons, cnt, hmin, hmax;

    // ************************************************************
    // Design, flash and wiring
    // ************************************************************
    bsc_top #(.BOOT_BASE(BASE), .FRAME_LEN(FLEN)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .spi_rate_i(rate), .flash_data_in_i(fdata),
        .spi_o(spi), .host_serial_clk_i(scl), .host_serial_dat_i(sda_w),
        .host_serial_dat_o(dat_o), .host_serial_dat_oe_o(dat_oe),
        .bus_id_select_i(strap), .frame_sync_i(fsync), .cfg_o(cfg),
        .bias_en_o(bias), .boot_done_o(done), .frame_pos_o(pos),
        .frame_align_o(align));
    bsc_flash_model flash (.spi_i(spi), .slow_i(slow), .data_o(fdata), .hdr_o());
    // Open-drain data line with pull-up; unknown enable pulls low
    assign sda_w = (dat_oe !== 1'b0) ? 1'b0 : sda;

    always #12.5 clk_i = ~clk_i;

    // Write strobes and flash clock half periods
    always @(posedge clk_i) begin
        if (cfg.wr === 1'b1) wq.push_back({cfg.addr, cfg.data});
        if (rst_i || spi.cs_n !== 1'b0) cnt = 0;
        else if (spi.sclk !== sclk_prev) begin
            if (cnt + 1 < hmin) hmin = cnt + 1;
            if (cnt + 1 > hmax) hmax = cnt + 1;
            cnt = 0;
        end else cnt = cnt + 1;
        if (rst_i) hmin = 99;
        if (rst_i) hmax = 0;
        sclk_prev = spi.sclk;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic tw_byte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_i) scl <= 1'b0;
            repeat (2) @(posedge clk_i);
            sda <= v[i];
            repeat (2) @(posedge clk_i);
            scl <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
        @(posedge clk_i) scl <= 1'b0;
        repeat (2) @(posedge clk_i);
        sda <= 1'b1;
        repeat (2) @(posedge clk_i);
        scl <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 ack = ~sda_w;
        repeat (2) @(posedge clk_i);
    endtask

    // Start, id, address, data, stop; one ack bit per byte
    task automatic tw_write(input logic [7:0] id, input logic [15:0] a, input logic [15:0] d,
                            output logic [4:0] ak);
        logic [39:0] b;
        logic        one;
        b = {id, a, d};
        @(posedge clk_i) sda <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int n = 0; n < 5; n++) begin
            tw_byte(b[39-8*n -: 8], one);
            ak[4-n] = one;
        end
        @(posedge clk_i) scl <= 1'b0;
        repeat (2) @(posedge clk_i);
        sda <= 1'b0;
        repeat (2) @(posedge clk_i);
        scl <= 1'b1;
        repeat (2) @(posedge clk_i);
        sda <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask

    // Set the address, repeated start, read one word and nack it
    task automatic tw_read(input logic [7:0] id, input logic [15:0] a,
                           output logic [15:0] v, output logic [3:0] ak);
        logic [17:0] rd;
        rd = '0;
        @(posedge clk_i) sda <= 1'b0;
        repeat (4) @(posedge clk_i);
        tw_byte(id, ak[3]);
        tw_byte(a[15:8], ak[2]);
        tw_byte(a[7:0], ak[1]);
        @(posedge clk_i) scl <= 1'b0;
        repeat (4) @(posedge clk_i);
        scl <= 1'b1;
        repeat (4) @(posedge clk_i);
        sda <= 1'b0;
        repeat (4) @(posedge clk_i);
        tw_byte(id | 8'h01, ak[0]);
        // Host acks the high byte and nacks the low one
        for (int i = 17; i >= 0; i--) begin
            @(posedge clk_i) scl <= 1'b0;
            repeat (2) @(posedge clk_i);
            sda <= (i != 9);
            repeat (2) @(posedge clk_i);
            scl <= 1'b1;
            repeat (2) @(posedge clk_i);
            #1 rd = {rd[16:0], sda_w};
            repeat (2) @(posedge clk_i);
        end
        v = {rd[17:10], rd[8:1]};
        @(posedge clk_i) scl <= 1'b0;
        repeat (2) @(posedge clk_i);
        sda <= 1'b0;
        repeat (2) @(posedge clk_i);
        scl <= 1'b1;
        repeat (2) @(posedge clk_i);
        sda <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Reset mid-run too, then boot at the given flash rate
    task automatic boot_run(input logic [1:0] r);
        logic [3:0] h;
        h = (r == 2'h0) ? SPI_HALF_SLOW : (r == 2'h1) ? SPI_HALF_MID : SPI_HALF_FAST;
        @(posedge clk_i) rst_i <= 1'b1;
        rate <= r;
        slow <= (r == 2'h0);
        repeat (5) @(posedge clk_i);
        #1 chk(spi.oe, 1'b0);
        chk(spi.cs_n, 1'b1);
        chk(dat_oe, 1'b0);
        chk(bias, 1'b1);
        chk({done, 11'h0, pos}, 32'h0);
        wq.delete();
        @(posedge clk_i) rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk({spi.oe, spi.cs_n}, 2'h2);
        for (int i = 0; i < 20000 && done !== 1'b1; i++) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        #1 chk(done, 1'b1);
        chk(spi.cs_n, 1'b1);
        chk(flash.hdr_o, {FLASH_READ_CMD, BASE});
        chk(wq.size(), 2);
        chk(wq[0], 32'h0014_0000);
        chk(wq[1], 32'h1234_abcd);
        chk(bias, 1'b0);
        chk(hmin, h);
        chk(hmax, h);
    endtask

    // Own id acked and written, the other id ignored, per strap level
    task automatic tw_run();
        logic [4:0]  ak;
        logic [7:0]  id;
        logic [15:0] dv;
        logic [15:0] rv;
        logic [3:0]  ra;
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_i) strap <= s[0];
            repeat (6) @(posedge clk_i);
            id = s[0] ? TW_ID_STRAP_HI : TW_ID_STRAP_LO;
            dv = s[0] ? 16'h0000 : 16'h4000;
            wq.delete();
            tw_write(id, 16'h0014, dv, ak);
            chk(ak, 5'h1f);
            chk(wq.size(), 1);
            chk(wq[0], {16'h0014, dv});
            chk(bias, dv[14]);
            tw_read(id, 16'h0014, rv, ra);
            chk(ra, 4'hf);
            chk(rv, dv);
            tw_write(id ^ 8'h2a, 16'h0014, ~dv, ak);
            chk(ak, 5'h00);
            chk(bias, dv[14]);
        end
        tw_read(TW_ID_STRAP_HI, REG_BOOT_STAT, rv, ra);
        chk({ra, rv}, 20'hf0001);
        chk(dat_o, 1'b0);
    endtask

    // Frame sync rise realigns, counter wraps at the frame length
    task automatic frame_run();
        @(posedge clk_i) fsync <= 1'b1;
        for (int i = 0; i < 10 && align !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk({align, 11'h0, pos}, 32'h8000_0000);
        @(posedge clk_i);
        #1 chk({align, 11'h0, pos}, 32'h1);
        repeat (int'(FLEN) - 1) @(posedge clk_i);
        #1 chk(pos, 20'h0);
        @(posedge clk_i) fsync <= 1'b0;
    endtask

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        rate = 2'h0;
        scl = 1'b1;
        sda = 1'b1;
        strap = 1'b0;
        fsync = 1'b0;
        slow = 1'b0;
        img = 96'h0014_0000_1234_abcd_ffff_5a5a;
        for (int i = 0; i < 64; i++) flash.mem[i] = 8'h00;
        for (int i = 0; i < 12; i++) flash.mem[32 + i] = img[95-8*i -: 8];
        for (int r = 0; r < 3; r++) boot_run(r[1:0]);
        tw_run();
        frame_run();
        close_out();
    end

    // Watchdog well beyond the expected run of about 0.15 ms
    initial begin
        #2000000;
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
